// File: logic/svd_pkg.sv
`default_nettype none

package svd_pkg;

	// ----------------------------------------------------------------
	// Bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int unsigned SVD_AW = 2;
	localparam int unsigned SVD_DW = 8;
	localparam logic [SVD_AW-1:0] SVD_OFS_CONTROL = 2'h0;
	localparam logic [SVD_AW-1:0] SVD_OFS_REQUEST = 2'h1;
	localparam logic [SVD_AW-1:0] SVD_OFS_IRQ_EN = 2'h2;
	localparam logic [SVD_AW-1:0] SVD_OFS_GLOBAL = 2'h3;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned SVD_BIT_DIR = 7;
	localparam int unsigned SVD_BIT_UNUSED = 6;
	localparam int unsigned SVD_BIT_SETTLED = 5;
	localparam int unsigned SVD_BIT_PWR = 4;
	localparam int unsigned SVD_LVL_MSB = 3;
	localparam int unsigned SVD_LVL_LSB = 0;
	localparam int unsigned SVD_LVL_W = SVD_LVL_MSB - SVD_LVL_LSB + 1;
	localparam int unsigned SVD_BIT_EVENT = 2;
	localparam int unsigned SVD_BIT_GIE = 0;

	// ----------------------------------------------------------------
	// Reset values and level codes
	// ----------------------------------------------------------------
	localparam logic SVD_DIR_RESET = 1'h0;
	localparam logic SVD_PWR_RESET = 1'h0;
	localparam logic [SVD_LVL_W-1:0] SVD_LVL_RESET = 4'h5;
	localparam logic [SVD_LVL_W-1:0] SVD_LVL_MIN = 4'h0;
	localparam logic [SVD_LVL_W-1:0] SVD_LVL_MAX = 4'he;
	localparam logic [SVD_LVL_W-1:0] SVD_LVL_RESERVED = 4'hf;
	localparam logic [SVD_DW-1:0] SVD_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned SVD_CLK_PERIOD_NS = 40;
	localparam int unsigned SVD_SETTLE_TIME_NS = 20000;

	// ----------------------------------------------------------------
	// Detector states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SVD_ST_OFF,
		SVD_ST_SETTLING,
		SVD_ST_READY
	} svd_state_t;

	// Address match for one register access
	function automatic logic svd_hit(input logic strobe, input logic [SVD_AW-1:0] addr,
		input logic [SVD_AW-1:0] ofs);
		svd_hit = strobe && (addr == ofs);
	endfunction

endpackage

`default_nettype wire

// File: logic/svd_settle_timer.sv
`default_nettype none

module svd_settle_timer
	import svd_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = 500,
	parameter int unsigned CW = $clog2(SETTLE_CYCLES + 1) + 1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic run,
	output logic done
);

	// ----------------------------------------------------------------
	// Stabilization counter
	// ----------------------------------------------------------------
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic done_reg;
	logic done_next;

	// Restart on every stop, saturate at the interval end
	always_comb begin
		count_next = count_reg;
		done_next = done_reg;
		if (!run) begin
			count_next = '0;
			done_next = 1'b0;
		end else if (count_reg == CW'(SETTLE_CYCLES)) begin
			done_next = 1'b1;
		end else begin
			count_next = count_reg + CW'(1);
		end
	end

	// Counter registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg <= done_next;
		end
	end

	assign done = done_reg;

endmodule

`default_nettype wire

// File: logic/svd_top.sv
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none

module svd_top
	import svd_pkg::*;
#(
	parameter int unsigned SETTLE_TIME_NS = SVD_SETTLE_TIME_NS,
	parameter int unsigned CLK_PERIOD_NS = SVD_CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [SVD_AW-1:0] reg_addr,
	input wire logic [SVD_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [SVD_DW-1:0] reg_rdata,
	input wire logic supply_at_or_above,
	input wire logic supply_at_or_below,
	input wire logic ref_stable,
	input wire logic sleep_mode,
	output logic detector_power_enable,
	output logic [SVD_LVL_W-1:0] trip_level_code,
	output logic crossing_direction_select,
	output logic reference_settled_flag,
	output logic threshold_event_flag,
	output logic threshold_event_irq_enable,
	output logic supply_threshold_interrupt,
	output logic wake_request
);

	// ----------------------------------------------------------------
	// Derived timing
	// ----------------------------------------------------------------

	// Least time, rounded up, never below one cycle
	localparam int unsigned SETTLE_RAW = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic dir_reg;
	logic dir_next;
	logic pwr_reg;
	logic pwr_next;
	logic [SVD_LVL_W-1:0] lvl_reg;
	logic [SVD_LVL_W-1:0] lvl_next;
	logic event_reg;
	logic event_next;
	logic irq_en_reg;
	logic irq_en_next;
	logic gie_reg;
	logic gie_next;
	logic [SVD_DW-1:0] rdata_reg;
	logic [SVD_DW-1:0] rdata_next;
	svd_state_t state_reg;
	svd_state_t state_next;
	logic settled_reg;
	logic settled_next;
	logic ctrl_wr;
	logic req_wr;
	logic ien_wr;
	logic gie_wr;
	logic event_clear;
	logic crossing;
	logic event_set;
	logic timer_done;
	logic [SVD_DW-1:0] ctrl_view;
	logic [SVD_DW-1:0] req_view;
	logic [SVD_DW-1:0] ien_view;
	logic [SVD_DW-1:0] gie_view;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------

	// One strobe per register
	assign ctrl_wr = svd_hit(reg_wr, reg_addr, SVD_OFS_CONTROL);
	assign req_wr = svd_hit(reg_wr, reg_addr, SVD_OFS_REQUEST);
	assign ien_wr = svd_hit(reg_wr, reg_addr, SVD_OFS_IRQ_EN);
	assign gie_wr = svd_hit(reg_wr, reg_addr, SVD_OFS_GLOBAL);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------

	// Direction, power and level fields; bits 6 and 5 are not stored
	always_comb begin
		dir_next = dir_reg;
		pwr_next = pwr_reg;
		lvl_next = lvl_reg;
		if (ctrl_wr) begin
			dir_next = reg_wdata[SVD_BIT_DIR];
			pwr_next = reg_wdata[SVD_BIT_PWR];
			lvl_next = reg_wdata[SVD_LVL_MSB:SVD_LVL_LSB];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_reg <= SVD_DIR_RESET;
			pwr_reg <= SVD_PWR_RESET;
			lvl_reg <= SVD_LVL_RESET;
		end else begin
			dir_reg <= dir_next;
			pwr_reg <= pwr_next;
			lvl_reg <= lvl_next;
		end
	end

	// ----------------------------------------------------------------
	// Stabilization interval
	// ----------------------------------------------------------------

	// Counter runs only while powered, so each switch-on restarts it
	svd_settle_timer #(
		.SETTLE_CYCLES(SETTLE_CYCLES)
	) u_settle (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.run(pwr_reg),
		.done(timer_done)
	);

	// Detector sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SVD_ST_OFF: begin
				if (pwr_reg) begin
					state_next = SVD_ST_SETTLING;
				end
			end
			SVD_ST_SETTLING: begin
				if (!pwr_reg) begin
					state_next = SVD_ST_OFF;
				end else if (timer_done && ref_stable) begin
					state_next = SVD_ST_READY;
				end
			end
			SVD_ST_READY: begin
				if (!pwr_reg) begin
					state_next = SVD_ST_OFF;
				end
			end
			default: begin
				state_next = SVD_ST_OFF;
			end
		endcase
	end

	always_comb begin
		settled_next = (state_next == SVD_ST_READY);
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= SVD_ST_OFF;
			settled_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			settled_reg <= settled_next;
		end
	end

	// ----------------------------------------------------------------
	// Crossing detection
	// ----------------------------------------------------------------

	assign crossing = dir_reg ? supply_at_or_above : supply_at_or_below;

	assign event_set = pwr_reg && settled_reg && crossing;

	// ----------------------------------------------------------------
	// Request, enable and global enable registers
	// ----------------------------------------------------------------

	assign event_clear = req_wr && reg_wdata[SVD_BIT_EVENT];

	// Sticky flag, set beats clear; enables are plain storage
	always_comb begin
		event_next = event_reg;
		irq_en_next = irq_en_reg;
		gie_next = gie_reg;
		if (event_clear) begin
			event_next = 1'b0;
		end
		if (event_set) begin
			event_next = 1'b1;
		end
		if (ien_wr) begin
			irq_en_next = reg_wdata[SVD_BIT_EVENT];
		end
		if (gie_wr) begin
			gie_next = reg_wdata[SVD_BIT_GIE];
		end
	end

	// Flag and enable registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			event_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			gie_reg <= 1'b0;
		end else begin
			event_reg <= event_next;
			irq_en_reg <= irq_en_next;
			gie_reg <= gie_next;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Register images, unused bits zero
	always_comb begin
		ctrl_view = SVD_ZERO;
		ctrl_view[SVD_BIT_DIR] = dir_reg;
		ctrl_view[SVD_BIT_UNUSED] = 1'b0;
		ctrl_view[SVD_BIT_SETTLED] = settled_reg;
		ctrl_view[SVD_BIT_PWR] = pwr_reg;
		ctrl_view[SVD_LVL_MSB:SVD_LVL_LSB] = lvl_reg;
		req_view = SVD_ZERO;
		req_view[SVD_BIT_EVENT] = event_reg;
		ien_view = SVD_ZERO;
		ien_view[SVD_BIT_EVENT] = irq_en_reg;
		gie_view = SVD_ZERO;
		gie_view[SVD_BIT_GIE] = gie_reg;
	end

	// Data valid only in the cycle after the read strobe
	always_comb begin
		rdata_next = SVD_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				SVD_OFS_CONTROL: begin
					rdata_next = ctrl_view;
				end
				SVD_OFS_REQUEST: begin
					rdata_next = req_view;
				end
				SVD_OFS_IRQ_EN: begin
					rdata_next = ien_view;
				end
				SVD_OFS_GLOBAL: begin
					rdata_next = gie_view;
				end
				default: begin
					rdata_next = SVD_ZERO;
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= SVD_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Analog side controls, straight from storage
	assign detector_power_enable = pwr_reg;
	assign trip_level_code = lvl_reg;
	assign crossing_direction_select = dir_reg;

	// Status copies for the system
	assign reference_settled_flag = settled_reg;
	assign threshold_event_flag = event_reg;
	assign threshold_event_irq_enable = irq_en_reg;
	assign reg_rdata = rdata_reg;

	assign supply_threshold_interrupt = event_reg && irq_en_reg && gie_reg;

	assign wake_request = event_reg && irq_en_reg && sleep_mode;

endmodule

`default_nettype wire

// File: testbench/svd_checker.sv
`default_nettype none

module svd_checker
	import svd_pkg::*;
#(
	parameter int unsigned SETTLE_TIME_NS = SVD_SETTLE_TIME_NS,
	parameter int unsigned CLK_PERIOD_NS = SVD_CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [SVD_AW-1:0] reg_addr,
	input wire logic [SVD_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [SVD_DW-1:0] reg_rdata,
	input wire logic supply_at_or_above,
	input wire logic supply_at_or_below,
	input wire logic ref_stable,
	input wire logic sleep_mode,
	input wire logic detector_power_enable,
	input wire logic [SVD_LVL_W-1:0] trip_level_code,
	input wire logic crossing_direction_select,
	input wire logic reference_settled_flag,
	input wire logic threshold_event_flag,
	input wire logic threshold_event_irq_enable,
	input wire logic supply_threshold_interrupt,
	input wire logic wake_request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [SVD_DW-1:0] wdata_q;

	// Last write data, for control field checks
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdata_q <= SVD_ZERO;
		end else begin
			wdata_q <= reg_wdata;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_unused_zero;
		reg_rd && reg_addr == SVD_OFS_CONTROL |=> reg_rdata[SVD_BIT_UNUSED] == 1'b0;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("control bit 6 read as one");
	property p_settled_read;
		reg_rd && reg_addr == SVD_OFS_CONTROL
			|=> reg_rdata[SVD_BIT_SETTLED] == $past(reference_settled_flag);
	endproperty
	a_settled_read: assert property (p_settled_read)
		else $error("settled bit read differs from flag");
	property p_no_early_flag;
		!reference_settled_flag && !threshold_event_flag |=> !threshold_event_flag;
	endproperty
	a_no_early_flag: assert property (p_no_early_flag)
		else $error("event flag set while unsettled");
	property p_rise_event;
		detector_power_enable && reference_settled_flag && crossing_direction_select
			&& supply_at_or_above |=> threshold_event_flag;
	endproperty
	a_rise_event: assert property (p_rise_event)
		else $error("rising crossing missed");
	property p_fall_event;
		detector_power_enable && reference_settled_flag && !crossing_direction_select
			&& supply_at_or_below |=> threshold_event_flag;
	endproperty
	a_fall_event: assert property (p_fall_event)
		else $error("falling crossing missed");
	property p_sticky;
		threshold_event_flag
			&& !(reg_wr && reg_addr == SVD_OFS_REQUEST && reg_wdata[SVD_BIT_EVENT])
			|=> threshold_event_flag;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("event flag lost without clear");
	property p_ctrl_write;
		reg_wr && reg_addr == SVD_OFS_CONTROL
			|=> detector_power_enable == wdata_q[SVD_BIT_PWR]
			&& trip_level_code == wdata_q[SVD_LVL_MSB:SVD_LVL_LSB]
			&& crossing_direction_select == wdata_q[SVD_BIT_DIR];
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control fields not updated");
	property p_settled_off;
		!detector_power_enable |=> !reference_settled_flag;
	endproperty
	a_settled_off: assert property (p_settled_off)
		else $error("settled kept while off");
	property p_fresh_interval;
		$rose(detector_power_enable) |-> !reference_settled_flag [*4];
	endproperty
	a_fresh_interval: assert property (p_fresh_interval)
		else $error("settled too soon after enable");
	property p_wake;
		wake_request == (threshold_event_flag && threshold_event_irq_enable && sleep_mode);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake request mismatch");
endmodule

bind svd_top svd_checker #(
	.SETTLE_TIME_NS(SETTLE_TIME_NS),
	.CLK_PERIOD_NS(CLK_PERIOD_NS)
) u_chk (.*);

`default_nettype wire

// File: testbench/tb.sv
`default_nettype none

module tb;
	import svd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, arst_n, reg_wr, reg_rd, sleep_mode, ref_stable;
	logic supply_at_or_above, supply_at_or_below;
	logic [SVD_AW-1:0] reg_addr;
	logic [SVD_DW-1:0] reg_wdata, reg_rdata;
	logic [SVD_LVL_W-1:0] trip_level_code;
	logic detector_power_enable, crossing_direction_select, reference_settled_flag;
	logic threshold_event_flag, threshold_event_irq_enable, supply_threshold_interrupt;
	logic wake_request;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;

	svd_top #(.SETTLE_TIME_NS(200), .CLK_PERIOD_NS(40)) dut (.*);

	// Clock generation
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bit_chk(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [SVD_AW-1:0] a, input logic [SVD_DW-1:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [SVD_AW-1:0] a, input logic [SVD_DW-1:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic wait_settled();
		int k;
		k = 0;
		while (reference_settled_flag !== 1'b1 && k < 20) begin
			@(posedge ref_clk);
			#1 k++;
		end
		bit_chk(reference_settled_flag, 1'b1);
	endtask
	// One-cycle excursion, then flag judged
	task automatic pulse(input logic above, input logic exp);
		@(posedge ref_clk);
		supply_at_or_above <= above;
		supply_at_or_below <= !above;
		@(posedge ref_clk);
		supply_at_or_above <= 1'b0;
		supply_at_or_below <= 1'b0;
		@(posedge ref_clk);
		#1 bit_chk(threshold_event_flag, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_regs();
		rd_chk(SVD_OFS_CONTROL, 8'h05);
		rd_chk(SVD_OFS_REQUEST, 8'h00);
		wr(SVD_OFS_CONTROL, 8'hef);
		rd_chk(SVD_OFS_CONTROL, 8'h8f);
		wr(SVD_OFS_CONTROL, 8'h60);
		rd_chk(SVD_OFS_CONTROL, 8'h00);
		for (int i = 0; i < 16; i++) begin
			wr(SVD_OFS_CONTROL, 8'(i));
			#1 chk(8'(trip_level_code), 8'(i));
		end
		$display("test reset_regs done");
	endtask
	task automatic t_low_detect();
		wr(SVD_OFS_CONTROL, 8'h10);
		supply_at_or_below <= 1'b1;
		repeat (12) @(posedge ref_clk);
		#1 bit_chk(reference_settled_flag, 1'b0);
		bit_chk(threshold_event_flag, 1'b0);
		@(posedge ref_clk);
		supply_at_or_below <= 1'b0;
		ref_stable <= 1'b1;
		wait_settled();
		bit_chk(threshold_event_flag, 1'b0);
		rd_chk(SVD_OFS_CONTROL, 8'h30);
		wr(SVD_OFS_IRQ_EN, 8'h04);
		wr(SVD_OFS_GLOBAL, 8'h01);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		bit_chk(supply_threshold_interrupt, 1'b1);
		@(posedge ref_clk);
		sleep_mode <= 1'b1;
		#1 bit_chk(wake_request, 1'b1);
		rd_chk(SVD_OFS_REQUEST, 8'h04);
		rd_chk(SVD_OFS_IRQ_EN, 8'h04);
		wr(SVD_OFS_REQUEST, 8'h04);
		sleep_mode <= 1'b0;
		#1 bit_chk(threshold_event_flag, 1'b0);
		bit_chk(supply_threshold_interrupt, 1'b0);
		$display("test low_detect done");
	endtask
	task automatic t_high_detect();
		wr(SVD_OFS_CONTROL, 8'h0e);
		@(posedge ref_clk);
		#1 bit_chk(reference_settled_flag, 1'b0);
		wr(SVD_OFS_CONTROL, 8'h9e);
		#1 bit_chk(detector_power_enable, 1'b1);
		bit_chk(reference_settled_flag, 1'b0);
		wait_settled();
		pulse(1'b0, 1'b0);
		// Crossing while asleep
		@(posedge ref_clk);
		sleep_mode <= 1'b1;
		pulse(1'b1, 1'b1);
		bit_chk(wake_request, 1'b1);
		wr(SVD_OFS_GLOBAL, 8'h00);
		#1 bit_chk(supply_threshold_interrupt, 1'b0);
		bit_chk(wake_request, 1'b1);
		wr(SVD_OFS_REQUEST, 8'h04);
		sleep_mode <= 1'b0;
		$display("test high_detect done");
	endtask
	// Reset while powered and settled
	task automatic t_mid_reset();
		@(posedge ref_clk);
		arst_n <= 1'b0;
		@(posedge ref_clk);
		#1 bit_chk(detector_power_enable, 1'b0);
		bit_chk(reference_settled_flag, 1'b0);
		@(posedge ref_clk);
		arst_n <= 1'b1;
		rd_chk(SVD_OFS_CONTROL, 8'h05);
		$display("test mid_reset done");
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		supply_at_or_above = 1'b0;
		supply_at_or_below = 1'b0;
		ref_stable = 1'b0;
		sleep_mode = 1'b0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_reset_regs();
		t_low_detect();
		t_high_detect();
		t_mid_reset();
		report_and_stop();
	end
endmodule

`default_nettype wire
